// [common/pcstk_pkg.sv]
// Summary of operation
// - The program counter is 13 bits, addressing 8K words of 14 bits.
// - Each instruction is one word; the fetch path is 14 bits wide.
// - Four pages of 2K words are chosen by the top two counter bits.
// - Sequential increment crosses page boundaries without touching the latch.
// - Address bits above the implemented size are ignored, so fetches wrap.
// - Any reset sets the program counter to zero.
// - Any reset clears the counter high latch to zero.
// - Interrupt acknowledge loads address 4 and leaves the latch alone.
// - Low byte is readable and writable; upper five bits are written only via latch.
// - A low-byte write copies latch bits 4:0 into the counter's upper bits.
// - A jump takes page bits from latch bits 4:3 plus the 11-bit field.
// - A call saves the return address and takes page bits from latch 4:3.
// - Calls and interrupt vectoring both push the counter onto the stack.
// - Return, return-with-literal and interrupt return pop the full counter.
// - Stack is 8 by 13 bits, outside memory spaces, pointer invisible.
// - Pushes and pops leave the counter high latch unchanged.
// - The stack is circular; the ninth push overwrites the first.
// - There is no overflow or underflow flag.
// - Program memory has its own bus, separate from data memory.
// - Jump and call carry an 11-bit target field reaching one 2K page.
// - Small parts ignore latch page bits they cannot use.
package pcstk_pkg;
    localparam int PC_WIDTH = 13;
    localparam int INSTR_WIDTH = 14;
    localparam int TARGET_WIDTH = 11;
    localparam int LATCH_WIDTH = 5;
    localparam int STACK_DEPTH = 8;
    localparam int MEM_WORDS = 8192;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] LOW_RESET = 8'h00;
    localparam logic [1:0] REG_LOW = 2'h0;
    localparam logic [1:0] REG_LATCH = 2'h1;
    localparam logic [1:0] REG_STATE = 2'h2;
    typedef enum logic [2:0] {
        PCSTK_OP_NEXT, PCSTK_OP_JUMP, PCSTK_OP_CALL, PCSTK_OP_RET,
        PCSTK_OP_RETLIT, PCSTK_OP_RETIRQ, PCSTK_OP_HOLD
    } pcstk_op_e;
endpackage

// [common/pcstk_stk_if.sv]
`timescale 1ns/1ps
interface pcstk_stk_if;
    import pcstk_pkg::*;
    logic push;
    logic pop;
    logic [12:0] push_data;
    logic [12:0] top_data;
    modport ctrl (output push, output pop, output push_data, input top_data);
    modport stk (input push, input pop, input push_data, output top_data);
endinterface

// [rtl/pcstk_stack.sv]
`timescale 1ns/1ps
module pcstk_stack
    import pcstk_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    pcstk_stk_if.stk bus
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][12:0] mem;
        logic [PW-1:0] ptr;
    } pcstk_stk_s;
    pcstk_stk_s st_reg, st_next;

    // The pointer simply wraps; no flag reports running off either end.
    always_comb begin
        st_next = st_reg;
        if (bus.push) begin
            st_next.mem[st_reg.ptr] = bus.push_data;
            st_next.ptr = st_reg.ptr + 1'b1;
        end else if (bus.pop) begin
            st_next.ptr = st_reg.ptr - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.top_data = st_reg.mem[st_reg.ptr - 1'b1];
endmodule // pcstk_stack

// [rtl/pcstk_regs.sv]
`timescale 1ns/1ps
module pcstk_regs
    import pcstk_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [12:0] pc,
    output logic [7:0] rdata,
    output logic [4:0] latch,
    output logic low_wr,
    output logic [7:0] low_wdata
);
    typedef struct packed {
        logic [7:0] rdata;
        logic [4:0] latch;
    } pcstk_reg_s;
    pcstk_reg_s r_reg, r_next;

    always_comb begin
        r_next = r_reg;
        r_next.rdata = 8'h00;
        if (wr && addr == REG_LATCH) begin
            r_next.latch = wdata[4:0];
        end
        if (rd) begin
            if (addr == REG_LOW) begin
                r_next.rdata = pc[7:0];
            end else if (addr == REG_LATCH) begin
                r_next.rdata = {3'h0, r_reg.latch};
            end else begin
                r_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= '{rdata: 8'h00, latch: LATCH_RESET[4:0]};
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata = r_reg.rdata;
    assign latch = r_reg.latch;
    assign low_wr = wr && addr == REG_LOW;
    assign low_wdata = wdata;
endmodule // pcstk_regs

// [rtl/pcstk_top.sv]
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module pcstk_top
    import pcstk_pkg::*;
#(
    parameter int IMPL_WORDS = MEM_WORDS
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic STEP,
    input wire logic [2:0] OP,
    input wire logic [10:0] TARGET,
    input wire logic [7:0] LITERAL,
    input wire logic IRQ_ACK,
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [12:0] PMEM_ADDR,
    input wire logic [13:0] PMEM_DATA,
    output logic [13:0] INSTR,
    output logic W_LOAD,
    output logic [7:0] W_DATA
);
    localparam int AW = (IMPL_WORDS <= 1) ? 1 : $clog2(IMPL_WORDS);
    localparam logic [12:0] ADDR_MASK = 13'((1 << AW) - 1);

    typedef struct packed {
        logic [12:0] pc;
        logic [13:0] instr;
        logic w_load;
        logic [7:0] w_data;
    } pcstk_top_s;
    pcstk_top_s s_reg, s_next;

    pcstk_stk_if stk ();
    logic [4:0] latch;
    logic low_wr;
    logic [7:0] low_wdata;
    logic [12:0] pc_inc;
    logic [12:0] page_target;

    pcstk_regs u_regs (
        .clock(CLOCK),
        .rst_b(RST_B),
        .addr(REG_ADDR),
        .wdata(REG_WDATA),
        .wr(REG_WR),
        .rd(REG_RD),
        .pc(s_reg.pc),
        .rdata(REG_RDATA),
        .latch(latch),
        .low_wr(low_wr),
        .low_wdata(low_wdata)
    );

    pcstk_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clock(CLOCK),
        .rst_b(RST_B),
        .bus(stk.stk)
    );

    // Small parts drop the latch page bits their memory cannot reach.
    function automatic logic [12:0] wrap(input logic [12:0] a);
        return a & ADDR_MASK;
    endfunction

    assign pc_inc = s_reg.pc + 13'h0001;
    assign page_target = {latch[4:3], TARGET};

    always_comb begin
        stk.push = 1'b0;
        stk.pop = 1'b0;
        stk.push_data = pc_inc;
        s_next = s_reg;
        s_next.w_load = 1'b0;
        if (IRQ_ACK) begin
            // The current counter, not its successor, is what returns.
            stk.push_data = s_reg.pc;
            stk.push = 1'b1;
            s_next.pc = IRQ_VECTOR;
        end else if (low_wr) begin
            s_next.pc = wrap({latch, low_wdata});
        end else if (STEP) begin
            s_next.pc = wrap(pc_inc);
            case (pcstk_op_e'(OP))
                PCSTK_OP_JUMP: begin
                    s_next.pc = wrap(page_target);
                end
                PCSTK_OP_CALL: begin
                    stk.push = 1'b1;
                    s_next.pc = wrap(page_target);
                end
                PCSTK_OP_RET, PCSTK_OP_RETIRQ: begin
                    stk.pop = 1'b1;
                    // Pushed values are unmasked, so a small part wraps here.
                    s_next.pc = wrap(stk.top_data);
                end
                PCSTK_OP_RETLIT: begin
                    stk.pop = 1'b1;
                    s_next.pc = wrap(stk.top_data);
                    s_next.w_load = 1'b1;
                    s_next.w_data = LITERAL;
                end
                PCSTK_OP_HOLD: begin
                    s_next.pc = s_reg.pc;
                end
                default: begin
                end
            endcase
        end
        // The fetch bus is separate, so a fetch happens every cycle.
        s_next.instr = PMEM_DATA;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s_reg <= '{pc: RESET_VECTOR, instr: 14'h0000, w_load: 1'b0,
                       w_data: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign PMEM_ADDR = s_reg.pc;
    assign INSTR = s_reg.instr;
    assign W_LOAD = s_reg.w_load;
    assign W_DATA = s_reg.w_data;
endmodule // pcstk_top

// [bench/pcstk_mem_model.sv]
`timescale 1ns/1ps
module pcstk_mem_model (
    input wire logic [12:0] addr,
    output logic [13:0] data
);
    // Each address returns a distinct word so that a stale fetch shows up.
    assign data = {addr, 1'b1} ^ 14'h2A5A;
endmodule // pcstk_mem_model

// [bench/pcstk_top_assertions.sv]
`timescale 1ns/1ps
module pcstk_top_assertions
    import pcstk_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic STEP,
    input wire logic [2:0] OP,
    input wire logic [10:0] TARGET,
    input wire logic [7:0] LITERAL,
    input wire logic IRQ_ACK,
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic [12:0] PMEM_ADDR,
    input wire logic [13:0] PMEM_DATA,
    input wire logic [13:0] INSTR,
    input wire logic W_LOAD,
    input wire logic [7:0] W_DATA
);
    logic [4:0] lat_m;
    wire pw = REG_WR && REG_ADDR == REG_LOW && !IRQ_ACK;
    wire ex = STEP && !IRQ_ACK && !(REG_WR && REG_ADDR == REG_LOW);
    // Mirror of the latch, so page bits can be predicted from bus traffic.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            lat_m <= LATCH_RESET[4:0];
        end else if (REG_WR && REG_ADDR == REG_LATCH) begin
            lat_m <= REG_WDATA[4:0];
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    property p_rst; $rose(RST_B) |-> PMEM_ADDR == RESET_VECTOR; endproperty
    a_rst: assert property (p_rst) else $error("reset vector");
    property p_irq; IRQ_ACK |=> PMEM_ADDR == IRQ_VECTOR; endproperty
    a_irq: assert property (p_irq) else $error("irq vector");
    property p_nxt;
        ex && OP == PCSTK_OP_NEXT |=> PMEM_ADDR == $past(PMEM_ADDR) + 13'h1;
    endproperty
    a_nxt: assert property (p_nxt) else $error("increment");
    property p_jmp;
        ex && OP == PCSTK_OP_JUMP
            |=> PMEM_ADDR == {$past(lat_m[4:3]), $past(TARGET)};
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target");
    property p_low;
        pw |=> PMEM_ADDR == {$past(lat_m), $past(REG_WDATA)};
    endproperty
    a_low: assert property (p_low) else $error("low byte write");
    property p_fetch;
        $past(RST_B) |-> INSTR == $past(PMEM_DATA);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch word");
    property p_lit;
        ex && OP == PCSTK_OP_RETLIT |=> W_LOAD && W_DATA == $past(LITERAL);
    endproperty
    a_lit: assert property (p_lit) else $error("literal load");
    property p_rd2; REG_RD && REG_ADDR == REG_STATE |=> REG_RDATA == 8'h00;
    endproperty
    a_rd2: assert property (p_rd2) else $error("hidden read");
    property p_cr;
        ex && OP == PCSTK_OP_CALL ##1 ex && OP == PCSTK_OP_RET
            |=> PMEM_ADDR == $past(PMEM_ADDR, 2) + 13'h1;
    endproperty
    a_cr: assert property (p_cr) else $error("call return");
    c_irq: cover property (IRQ_ACK ##1 PMEM_ADDR == IRQ_VECTOR);
    c_cr: cover property (ex && OP == PCSTK_OP_CALL ##1 ex);
    c_lit: cover property (W_LOAD);
endmodule // pcstk_top_assertions

bind pcstk_top pcstk_top_assertions chk_u (.CLOCK, .RST_B, .STEP, .OP,
    .TARGET, .LITERAL, .IRQ_ACK, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .PMEM_ADDR, .PMEM_DATA, .INSTR, .W_LOAD, .W_DATA);

// [bench/test_pcstk_top.sv]
`timescale 1ns/1ps
module test_pcstk_top;
    import pcstk_pkg::*;
    logic CLOCK = '0, RST_B = '0, STEP = '0, IRQ_ACK = '0;
    logic REG_WR = '0, REG_RD = '0, W_LOAD, pend = '0, pend_d = '0;
    logic [2:0] OP = '0;
    logic [10:0] TARGET = '0;
    logic [7:0] LITERAL = '0, REG_WDATA = '0, REG_RDATA, W_DATA;
    logic [1:0] REG_ADDR = '0;
    logic [12:0] PMEM_ADDR, pc, got, stk [8];
    logic [13:0] PMEM_DATA, INSTR;
    logic [14:0] q [$];
    logic [14:0] n;
    logic [2:0] sp;
    logic [4:0] lat;
    int num_errors = 0, comparisons = 0, i;
    always #5 CLOCK = ~CLOCK;
    pcstk_top dut_u (.CLOCK, .RST_B, .STEP, .OP, .TARGET, .LITERAL, .IRQ_ACK,
        .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PMEM_ADDR,
        .PMEM_DATA, .INSTR, .W_LOAD, .W_DATA);
    pcstk_mem_model mem_u (.addr(PMEM_ADDR), .data(PMEM_DATA));
    // Bits of c are step, interrupt, write, read; d[9:8] is the index.
    task automatic drv(input logic [2:0] op, input logic [3:0] c,
        input logic [10:0] d, input logic [1:0] k, input logic [12:0] e);
        @(posedge CLOCK);
        {STEP, IRQ_ACK, REG_WR, REG_RD} <= c;
        OP <= op;
        TARGET <= d;
        LITERAL <= d[7:0];
        REG_WDATA <= d[7:0];
        REG_ADDR <= d[9:8];
        pend <= k != 2'h3;
        if (k != 2'h3) q.push_back({k, e});
    endtask
    task automatic close_out;
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge CLOCK) pend_d <= pend;
    // Kind 0 watches the fetch address, kind 1 the register read data.
    always @(negedge CLOCK) begin
        if (pend_d) begin
            n = q.pop_front();
            got = n[13] ? {5'h00, REG_RDATA} : PMEM_ADDR;
            comparisons++;
            if (got !== n[12:0]) begin
                $display("MISMATCH %s exp %h got %h",
                    n[13] ? "REG_RDATA" : "PMEM_ADDR", n[12:0], got);
                num_errors++;
            end
        end
    end
    initial begin
        repeat (600) @(posedge CLOCK);
        num_errors++;
        close_out;
    end
    initial begin
        void'($urandom(21));
        repeat (16) @(posedge CLOCK);
        RST_B <= 1'b1;
        drv(3'h0, 4'h0, 11'h000, 2'h0, 13'h0000);
        drv(3'h0, 4'h1, 11'h100, 2'h1, 13'h0000);
        drv(3'h0, 4'h2, 11'h1EA, 2'h3, 13'h0000);
        drv(3'h0, 4'h1, 11'h100, 2'h1, 13'h000A);
        drv(3'h1, 4'h8, 11'h7FF, 2'h0, 13'h0FFF);
        drv(3'h0, 4'h8, 11'h000, 2'h0, 13'h1000);
        drv(3'h0, 4'h2, 11'h034, 2'h0, 13'h0A34);
        drv(3'h0, 4'h1, 11'h000, 2'h1, 13'h0034);
        pc = 13'h0A34;
        sp = 3'h0;
        // Nine calls wrap the eight-entry stack and overwrite the first.
        for (i = 0; i < 9; i++) begin
            lat = 5'($urandom);
            drv(3'h0, 4'h2, {3'h1, 3'h0, lat}, 2'h3, 13'h0000);
            stk[sp] = pc + 13'h1;
            sp++;
            pc = {lat[4:3], 11'($urandom)};
            drv(3'h2, 4'h8, pc[10:0], 2'h0, pc);
        end
        for (i = 0; i < 9; i++) begin
            sp--;
            pc = stk[sp];
            drv(3'(3 + i % 3), 4'h8, 11'h0C3 + 11'(i), 2'h0, pc);
        end
        drv(3'h1, 4'hC, 11'h123, 2'h0, IRQ_VECTOR);
        // Service code saves, sets and restores the latch around a low-byte write.
        drv(3'h0, 4'h1, 11'h100, 2'h1, {8'h00, lat});
        drv(3'h0, 4'h2, 11'h103, 2'h3, 13'h0000);
        drv(3'h0, 4'h2, 11'h010, 2'h0, 13'h0310);
        drv(3'h0, 4'h2, {3'h1, 3'h0, lat}, 2'h3, 13'h0000);
        drv(3'h5, 4'h8, 11'h000, 2'h0, pc);
        drv(3'h0, 4'h1, 11'h100, 2'h1, {8'h00, lat});
        drv(3'h0, 4'h1, 11'h200, 2'h1, 13'h0000);
        drv(3'h0, 4'h0, 11'h000, 2'h0, pc);
        drv(3'h0, 4'h0, 11'h000, 2'h3, 13'h0000);
        repeat (3) @(posedge CLOCK);
        close_out;
    end
endmodule // test_pcstk_top
